/* File: chain_ref_peer.sv */
// Purpose: external reference source on the sync cable
// Assumes: runs on mclk_i, HALF sets its speed
// Notes:   lets go of the cable while the drive is master
`timescale 1ns/100ps

module chain_ref_peer
#(
    parameter HALF = 20 // cycles per half period
)
(
    // clock and reset
    input  wire mclk_i,
    input  wire rst_i,
    // cable
    input  wire busy_i,     // drive under test is master
    output wire peer_ref_o  // level this source puts out
);
reg [7:0] cnt_reg; // half period counter
reg       ref_reg; // free running reference

// ==========================================================
// reference source runs
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
        cnt_reg <= 8'h00;
    else if (cnt_reg == HALF - 1)
        cnt_reg <= 8'h00;
    else
        cnt_reg <= cnt_reg + 8'h01;
end
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
        ref_reg <= 1'b0;
    else if (cnt_reg == HALF - 1)
        ref_reg <= ~ref_reg;
end
// one master only: released output churns, never holds
assign peer_ref_o = busy_i ? cnt_reg[0] : ref_reg;
endmodule // chain_ref_peer

/* File: master_select_sva.sv */
// Purpose: port checks for the master select block
// Assumes: one clock mclk_i, rst_i async active high
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/100ps

module master_select_sva
(
    // clock and reset
    input wire        mclk_i,
    input wire        rst_i,
    // register bus
    input wire [4:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    // switch and cable
    input wire        master_switch_i,
    input wire        chain_ref_i,
    input wire        local_ref_i,
    input wire        sync_ref_o,
    input wire        sync_ref_oe_o,
    input wire        motor_ref_o
);
default clocking cb @(posedge mclk_i); endclocking
default disable iff (rst_i);

// ==========================================================
// quiet time: no write and no switch movement
reg [3:0] quiet_reg; // saturates, long enough for sync lag
always @(posedge mclk_i or posedge rst_i)
begin
    if (rst_i)
        quiet_reg <= 4'h0;
    else if (avs_write_i || !$stable(master_switch_i))
        quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
        quiet_reg <= quiet_reg + 4'h1;
end

// ==========================================================
// steady stretches of the inputs
sequence sw_on_s;
    master_switch_i[*8];
endsequence
sequence lead_hi_s;
    (sync_ref_oe_o && local_ref_i)[*8];
endsequence
sequence chain_hi_s;
    (!sync_ref_oe_o && chain_ref_i)[*8];
endsequence

// ==========================================================
// assertions
read_answer_a: assert property ($rose(avs_read_i || avs_write_i)
    |=> !avs_waitrequest_o) else $error("bus answer late");
wait_one_a: assert property (!avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer held too long");
unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i > 5'h14 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
oe_data_a: assert property (!sync_ref_oe_o |-> !sync_ref_o)
    else $error("cable data while not driving");
switch_master_a: assert property (sw_on_s |-> sync_ref_oe_o)
    else $error("switch closed but not driving");
role_quiet_a: assert property (quiet_reg == 4'hF
    |-> $stable(sync_ref_oe_o)) else $error("role moved alone");
drive_ref_a: assert property (lead_hi_s |-> sync_ref_o)
    else $error("master not driving its reference");
slave_follow_a: assert property (chain_hi_s |-> motor_ref_o)
    else $error("slave not following cable");
endmodule // master_select_sva

bind spindle_sync_master_select master_select_sva u_sva
(
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .master_switch_i(master_switch_i), .chain_ref_i(chain_ref_i),
    .local_ref_i(local_ref_i), .sync_ref_o(sync_ref_o),
    .sync_ref_oe_o(sync_ref_oe_o), .motor_ref_o(motor_ref_o)
);

/* File: spindle_sync_consts.vh */
// Purpose: constants for the spindle sync master select block
// Assumes: 100 MHz mclk_i, Avalon-MM register slave, byte addresses
// Notes:   offsets are byte addresses of aligned 32-bit words
//
// Overview of operation
// RULE_01: switch closed makes drive the sync master
// RULE_02: switch open by default, drive is slave
// RULE_03: commands honoured only while switch open
// RULE_04: function 2F makes selected drive master
// RULE_05: function 2E ends mastership, follow other reference
// RULE_06: 2F under switch mastership rejected with fault
// RULE_07: 2E under switch mastership rejected likewise
// RULE_08: host keeps at most one master on chain
// RULE_09: no master: follow external reference signal
// RULE_10: accepted function updates state, normal ending
`ifndef SPINDLE_SYNC_CONSTS_VH
`define SPINDLE_SYNC_CONSTS_VH

// ==========================================================
// bus control and function codes
`define BC_LOAD_DRIVE_FUNC  8'h01
`define FN_ENABLE_MASTER    8'h2F
`define FN_DISABLE_MASTER   8'h2E

// ==========================================================
// ending status bit positions
`define ST_O0_BC_EXC_BIT    5
`define ST_O2_BAD_ARG_BIT   6

// ==========================================================
// register byte offsets
`define REG_CTRL     5'h00
`define REG_CMD      5'h04
`define REG_STATUS   5'h08
`define REG_ENDING   5'h0C
`define REG_IRQ_STAT 5'h10
`define REG_IRQ_MASK 5'h14

// ==========================================================
// field positions and reset values
`define CTRL_CMD_MASTER_BIT 0
`define ST_MASTER_BIT       0
`define ST_SWITCH_BIT       1
`define ST_CMD_MASTER_BIT   2
`define ST_EXT_REF_BIT      3
`define ST_BUSY_BIT         4
`define IRQ_DONE_BIT        0
`define IRQ_REJECT_BIT      1
`define IRQ_ROLE_BIT        2
`define IRQ_MASK_RST        3'h0
`define READ_LAT            1

`endif

/* File: spindle_sync_master_select.v */
// Purpose: decides spindle sync mastership from switch and commands
// Assumes: switch, cable reference and local reference are async pins
// Notes:   commands arrive as register writes from the interface logic
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "spindle_sync_consts.vh"

module spindle_sync_master_select
(
    // clock and reset
    input  wire        mclk_i,
    input  wire        rst_i,
    // avalon-mm slave
    input  wire [4:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // rear panel switch and sync cable
    input  wire        master_switch_i,   // high when switch closed
    input  wire        chain_ref_i,       // reference on the cable
    input  wire        local_ref_i,       // own reference source
    output reg         sync_ref_o,        // cable driver data
    output reg         sync_ref_oe_o,     // cable driver enable
    output reg         motor_ref_o,       // reference to motor loop
    // interrupt
    output reg         irq_o
);

    // ==========================================================
    // synchronisers for pins
    reg [1:0] sw_sync_reg;     // switch two-stage
    reg [1:0] chain_sync_reg;  // cable reference two-stage
    reg [1:0] local_sync_reg;  // local reference two-stage

    // the pins move with no regard to mclk_i; two stages keep a
    // metastable first flop away from every decision below
    // first stage is read only by the second
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sw_sync_reg    <= 2'h0;
            chain_sync_reg <= 2'h0;
            local_sync_reg <= 2'h0;
        end
        else
        begin
            sw_sync_reg    <= {sw_sync_reg[0], master_switch_i};
            chain_sync_reg <= {chain_sync_reg[0], chain_ref_i};
            local_sync_reg <= {local_sync_reg[0], local_ref_i};
        end
    end

    // a two-cycle lag is harmless for a hand-set panel switch,
    // though a bouncing contact still reaches the judgement logic
    wire switch_on = sw_sync_reg[1];   // switch closed, synced

    // ==========================================================
    // command state machine
    // one command at a time: latch in idle, judge it in exec,
    // then a done cycle so busy stays up long enough to poll;
    // writes to the command word while busy are dropped
    localparam [1:0] ST_IDLE  = 2'h0;  // waiting for command
    localparam [1:0] ST_EXEC  = 2'h1;  // judging the command
    localparam [1:0] ST_DONE  = 2'h2;  // posting ending status

    reg [1:0]  state_reg;          // machine state
    reg [1:0]  state_next;
    reg [7:0]  bc_reg;             // latched bus control code
    reg [7:0]  fn_reg;             // latched function code
    reg        cmd_master_reg;     // master by command
    reg        cmd_master_next;
    reg        reject_next;        // command rejected
    reg        accept_next;        // command accepted
    reg [31:0] ending_reg;         // ending status octets 0..3
    reg        ctrl_en_reg;        // software allows command path

    wire cmd_wr;                   // write to command register
    wire bus_go;                   // bus access taken this edge

    // ----------------------------------------------------------
    // helper: is this a load drive function with given code
    function is_fn;
        input [7:0] bc;
        input [7:0] fn;
        input [7:0] code;
        begin
            is_fn = (bc == `BC_LOAD_DRIVE_FUNC) && (fn == code);
        end
    endfunction

    // ----------------------------------------------------------
    // helper: register offset decode, used by the write strobes only
    function addr_is;
        input [4:0] addr;          // bus address
        input [4:0] off;           // register offset
        begin
            addr_is = (addr == off);
        end
    endfunction

    // ----------------------------------------------------------
    // next state and judgement
    // the switch is read at exec time, so a switch flipped while
    // a command waits decides that command's fate
    always @*
    begin
        state_next      = state_reg;
        cmd_master_next = cmd_master_reg;
        reject_next     = 1'b0;
        accept_next     = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                // new command only through the register
                if (cmd_wr)
                    state_next = ST_EXEC;
            end
            ST_EXEC:
            begin
                // one cycle of judgement, whatever the code
                state_next = ST_DONE;
                if (is_fn(bc_reg, fn_reg, `FN_ENABLE_MASTER))
                begin
                    // RULE_03: switch off only
                    if (switch_on)
                        // RULE_06: reject enable
                        reject_next = 1'b1;
                    else
                    begin
                        // RULE_04: become master
                        cmd_master_next = 1'b1;
                        accept_next     = 1'b1;
                    end
                end
                else if (is_fn(bc_reg, fn_reg, `FN_DISABLE_MASTER))
                begin
                    if (switch_on)
                        // RULE_07: reject disable
                        reject_next = 1'b1;
                    else
                    begin
                        // RULE_05: cease mastership
                        cmd_master_next = 1'b0;
                        accept_next     = 1'b1;
                    end
                end
                else
                    // other codes are not this block's business
                    accept_next = 1'b1;
            end
            ST_DONE:
                // ending status is posted, free again
                state_next = ST_IDLE;
            default:
                // unused code, recover to idle
                state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------
    // state, command latch and ending status
    // ending status keeps the last verdict until the next command
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg      <= ST_IDLE;
            bc_reg         <= 8'h00;
            fn_reg         <= 8'h00;
            // RULE_02: factory slave state
            cmd_master_reg <= 1'b0;
            ending_reg     <= 32'h00000000;
        end
        else
        begin
            state_reg      <= state_next;
            cmd_master_reg <= cmd_master_next;
            if (cmd_wr && state_reg == ST_IDLE)
            begin
                // code octets of the command word
                bc_reg <= avs_writedata_i[15:8];
                fn_reg <= avs_writedata_i[7:0];
            end
            if (reject_next)
            begin
                // RULE_06: fault and bad argument
                ending_reg <= 32'h00000000;
                ending_reg[`ST_O0_BC_EXC_BIT]       <= 1'b1;
                ending_reg[16 + `ST_O2_BAD_ARG_BIT] <= 1'b1;
            end
            else if (accept_next)
                // RULE_10: normal ending status
                ending_reg <= 32'h00000000;
        end
    end

    // ==========================================================
    // mastership and cable drive
    // the switch always wins; commands only matter while it is open
    // command mastership is kept while the switch is closed, so
    // opening the switch falls back to what the host last asked for
    // RULE_01: switch makes master
    wire master_now = switch_on | (ctrl_en_reg & cmd_master_reg);
    wire ref_sel;                  // reference chosen by selector
    wire drv_en;                   // cable driver enable
    reg  master_q_reg;             // last master level for events

    // selector adds one register stage before the pin flops
    sync_ref_select u_sel
    (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .master_i    (master_now),
        .local_ref_i (local_sync_reg[1]),
        .chain_ref_i (chain_sync_reg[1]),
        .ref_o       (ref_sel),
        .drive_en_o  (drv_en)
    );

    // registered pin outputs
    // cable data is forced low while the driver is off, so the
    // cable never sees a stray level from this drive as a slave
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_ref_o    <= 1'b0;
            sync_ref_oe_o <= 1'b0;
            motor_ref_o   <= 1'b0;
            master_q_reg  <= 1'b0;
        end
        else
        begin
            // RULE_09: slave follows chain reference
            motor_ref_o   <= ref_sel;
            sync_ref_o    <= ref_sel & drv_en;
            // RULE_01: drive the cable
            sync_ref_oe_o <= drv_en;
            master_q_reg  <= master_now;
        end
    end

    // ==========================================================
    // interrupts: done, reject, role change
    // each event is one cycle wide and lands in a sticky bit; a
    // clear in the same cycle loses, so no event is ever dropped
    reg [2:0] irq_stat_reg;        // sticky events
    reg [2:0] irq_mask_reg;        // enable mask
    // bit 0 done, bit 1 rejected, bit 2 role changed
    wire [2:0] irq_event = {master_now ^ master_q_reg,
                            reject_next,
                            reject_next | accept_next};
    wire [2:0] irq_clr;            // write-one-to-clear lanes
    wire [2:0] irq_stat_next;      // status after set and clear

    // ==========================================================
    // avalon slave: one wait cycle on every access
    // the wait cycle lets read data come from a register; the cost
    // is one extra cycle on every access
    reg        ack_reg;            // access answered this cycle
    wire       req = (avs_read_i | avs_write_i);
    wire       take = req & ~ack_reg;  // request seen, answer next
    assign bus_go  = req & ack_reg;
    wire       wr_go = bus_go & avs_write_i;  // write lands now
    assign cmd_wr  = wr_go & addr_is(avs_address_i, `REG_CMD);
    assign irq_clr = (wr_go & addr_is(avs_address_i, `REG_IRQ_STAT)) ?
                     avs_writedata_i[2:0] : 3'h0;
    // set wins over a clear that falls in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_event;

    // read mux
    // unmapped and unaligned offsets read as zero
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        case (avs_address_i)
            `REG_CTRL:
                // command path enable
                rd_mux[`CTRL_CMD_MASTER_BIT] = ctrl_en_reg;
            `REG_CMD:
                // last command taken
                rd_mux[15:0] = {bc_reg, fn_reg};
            `REG_STATUS:
            begin
                rd_mux[`ST_MASTER_BIT]     = master_now;
                rd_mux[`ST_SWITCH_BIT]     = switch_on;
                rd_mux[`ST_CMD_MASTER_BIT] = cmd_master_reg;
                rd_mux[`ST_EXT_REF_BIT]    = ~master_now;
                rd_mux[`ST_BUSY_BIT]       = (state_reg != ST_IDLE);
            end
            `REG_ENDING:
                // verdict of the last command
                rd_mux = ending_reg;
            `REG_IRQ_STAT:
                rd_mux[2:0] = irq_stat_reg;
            `REG_IRQ_MASK:
                rd_mux[2:0] = irq_mask_reg;
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    // bus registers and interrupt state
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_reg           <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
            // command path enabled out of reset
            ctrl_en_reg       <= 1'b1;
            irq_stat_reg      <= 3'h0;
            irq_mask_reg      <= `IRQ_MASK_RST;
            irq_o             <= 1'b0;
        end
        else
        begin
            // answer one cycle after request rises
            ack_reg           <= take;
            avs_waitrequest_o <= ~take;
            // read data sampled once, held until the next access
            if (take)
                avs_readdata_o <= rd_mux;
            // writes land on the edge that completes the access
            if (wr_go)
            begin
                if (addr_is(avs_address_i, `REG_CTRL))
                    ctrl_en_reg <= avs_writedata_i[`CTRL_CMD_MASTER_BIT];
                if (addr_is(avs_address_i, `REG_IRQ_MASK))
                    irq_mask_reg <= avs_writedata_i[2:0];
            end
            // set beats clear
            irq_stat_reg <= irq_stat_next;
            // level output follows the new status, no extra lag
            irq_o        <= |(irq_stat_next & irq_mask_reg);
        end
    end

endmodule // spindle_sync_master_select

/* File: sync_ref_select.v */
// Purpose: picks the spindle reference source for the motor loop
// Assumes: all inputs already synchronised to mclk_i
// Notes:   registered outputs, one cycle latency
`timescale 1ns/100ps

module sync_ref_select
(
    // clock and reset
    input  wire mclk_i,
    input  wire rst_i,
    // role and sources
    input  wire master_i,       // drive is chain master
    input  wire local_ref_i,    // own crystal derived reference
    input  wire chain_ref_i,    // reference seen on the cable
    // results
    output reg  ref_o,          // reference fed to motor loop
    output reg  drive_en_o      // enable of cable driver
);

    // ==========================================================
    // source selection
    // master sources its own reference and drives the cable;
    // a slave follows whatever the cable carries
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_o      <= 1'b0;
            drive_en_o <= 1'b0;
        end
        else
        begin
            // RULE_09: follow external reference
            ref_o      <= master_i ? local_ref_i : chain_ref_i;
            // RULE_01: master drives cable
            drive_en_o <= master_i;
        end
    end

endmodule // sync_ref_select

/* File: testbench.sv */
// Purpose: register level test of the master select block
// Assumes: 100 MHz clock, Avalon-MM master tasks
// Notes:   cable level resolved here from both drivers
`timescale 1ns/100ps
`include "spindle_sync_consts.vh"

module testbench;
// ==========================================================
// signals
reg         mclk_i = 1'b0;
reg         rst_i = 1'b1;
reg  [4:0]  avs_address_i = 5'h00;
reg         avs_read_i = 1'b0;
reg         avs_write_i = 1'b0;
reg  [31:0] avs_writedata_i = 32'h0;
reg         master_switch_i = 1'b0;
reg         local_ref_i = 1'b0;
reg  [3:0]  lcnt_reg = 4'h0;
wire [31:0] avs_readdata_o;
wire        avs_waitrequest_o;
wire        sync_ref_o;
wire        sync_ref_oe_o;
wire        motor_ref_o;
wire        irq_o;
wire        peer_ref;
wire        chain_ref_i;
integer     err_count = 0;
integer     checks = 0;
integer     i;
reg  [31:0] rd;

// ==========================================================
// clock, local reference, cable wire
initial
begin
    forever #5 mclk_i = ~mclk_i;
end
always @(posedge mclk_i)
begin
    lcnt_reg <= lcnt_reg + 4'h1;
    if (lcnt_reg == 4'hF)
        local_ref_i <= ~local_ref_i;
end
assign chain_ref_i = sync_ref_oe_o ? sync_ref_o : peer_ref;

spindle_sync_master_select dut
(
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .master_switch_i(master_switch_i), .chain_ref_i(chain_ref_i),
    .local_ref_i(local_ref_i), .sync_ref_o(sync_ref_o),
    .sync_ref_oe_o(sync_ref_oe_o), .motor_ref_o(motor_ref_o),
    .irq_o(irq_o)
);
chain_ref_peer u_peer
(
    .mclk_i(mclk_i), .rst_i(rst_i), .busy_i(sync_ref_oe_o),
    .peer_ref_o(peer_ref)
);

// ==========================================================
// verdict, compare and bus tasks
task stop_test;
begin
    if (err_count == 0 && checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
task chk(input string nm, input [31:0] seen, input [31:0] exp);
begin
    checks = checks + 1;
    if (seen !== exp)
    begin
        err_count = err_count + 1;
        $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
end
endtask
// request held until waitrequest is sampled low
task bus(input w, input [4:0] a, input [31:0] d);
    integer n;
begin
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0)
    begin
        n = n + 1;
        if (n > 20)
        begin
            err_count = err_count + 1;
            stop_test;
        end
        @(posedge mclk_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
end
endtask
task rdx(input string nm, input [4:0] a, input [31:0] e);
begin
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
end
endtask
// poll until idle and the switch is seen
task settle;
    integer n;
begin
    n = 0;
    bus(1'b0, `REG_STATUS, 32'h0);
    while (rd[`ST_BUSY_BIT] !== 1'b0
        || rd[`ST_SWITCH_BIT] !== master_switch_i)
    begin
        n = n + 1;
        if (n > 20)
        begin
            err_count = err_count + 1;
            stop_test;
        end
        bus(1'b0, `REG_STATUS, 32'h0);
    end
end
endtask
task oe_is(input e);
    integer n;
begin
    n = 0;
    while (sync_ref_oe_o !== e && n < 10)
    begin
        @(posedge mclk_i);
        n = n + 1;
    end
    chk("cable drive", {31'h0, sync_ref_oe_o}, {31'h0, e});
end
endtask

// ==========================================================
// main sequence
initial
begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdx("status", `REG_STATUS, 32'h8);
    rdx("control", `REG_CTRL, 32'h1);
    rdx("mask", `REG_IRQ_MASK, 32'h0);
    bus(1'b1, 5'h18, 32'hFFFF_FFFF);
    rdx("unmapped", 5'h18, 32'h0);
    oe_is(1'b0);
    bus(1'b1, `REG_IRQ_MASK, 32'h7);
    bus(1'b1, `REG_CMD, 32'h0000_012F);
    settle;
    rdx("ending", `REG_ENDING, 32'h0);
    rdx("status", `REG_STATUS, 32'h5);
    oe_is(1'b1);
    rdx("events", `REG_IRQ_STAT, 32'h5);
    chk("irq", {31'h0, irq_o}, 32'h1);
    bus(1'b1, `REG_IRQ_STAT, 32'h7);
    rdx("events", `REG_IRQ_STAT, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    master_switch_i <= 1'b1;
    settle;
    rdx("status", `REG_STATUS, 32'h7);
    bus(1'b1, `REG_IRQ_MASK, 32'h0);
    for (i = 0; i < 2; i = i + 1)
    begin
        bus(1'b1, `REG_CMD, {16'h0, `BC_LOAD_DRIVE_FUNC,
            i ? `FN_DISABLE_MASTER : `FN_ENABLE_MASTER});
        settle;
        rdx("ending", `REG_ENDING, 32'h0040_0020);
        rdx("status", `REG_STATUS, 32'h7);
    end
    bus(1'b1, `REG_CMD, 32'h0000_0130);
    settle;
    rdx("command", `REG_CMD, 32'h0130);
    rdx("ending", `REG_ENDING, 32'h0);
    rdx("status", `REG_STATUS, 32'h7);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    bus(1'b0, `REG_IRQ_STAT, 32'h0);
    chk("reject event", rd & 32'h2, 32'h2);
    bus(1'b1, `REG_IRQ_MASK, 32'h2);
    rdx("mask", `REG_IRQ_MASK, 32'h2);
    chk("irq", {31'h0, irq_o}, 32'h1);
    bus(1'b1, `REG_IRQ_STAT, 32'h7);
    rdx("events", `REG_IRQ_STAT, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    master_switch_i <= 1'b0;
    settle;
    rdx("status", `REG_STATUS, 32'h5);
    bus(1'b1, `REG_CTRL, 32'h0);
    rdx("status", `REG_STATUS, 32'hC);
    oe_is(1'b0);
    bus(1'b1, `REG_CTRL, 32'h1);
    rdx("status", `REG_STATUS, 32'h5);
    bus(1'b1, `REG_CMD, 32'h0000_012E);
    settle;
    rdx("ending", `REG_ENDING, 32'h0);
    rdx("status", `REG_STATUS, 32'h8);
    oe_is(1'b0);
    repeat (60) @(posedge mclk_i);
    master_switch_i <= 1'b1;
    settle;
    rdx("status", `REG_STATUS, 32'h3);
    oe_is(1'b1);
    repeat (60) @(posedge mclk_i);
    stop_test;
end
endmodule // testbench
